/* rtl/pin_keeper.sv */
// file: two-flop synchroniser and weak hold for a group of pins
`timescale 1ns/100ps
module pin_keeper #(
  parameter int WIDTH = 12
) (
  input  wire logic             i_mclk,
  input  wire logic             i_rst,
  input  wire logic [WIDTH-1:0] i_level,
  input  wire logic [WIDTH-1:0] i_driven,
  output logic      [WIDTH-1:0] o_level
);
  logic [WIDTH-1:0] lvl_s1_r;
  logic [WIDTH-1:0] lvl_s2_r;
  logic [WIDTH-1:0] drv_s1_r;
  logic [WIDTH-1:0] drv_s2_r;
  logic [WIDTH-1:0] hold_r;

  // pins are asynchronous to i_mclk, so two flops before anything looks
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      lvl_s1_r <= '0;
      lvl_s2_r <= '0;
      drv_s1_r <= '0;
      drv_s2_r <= '0;
    end else begin
      lvl_s1_r <= i_level;
      lvl_s2_r <= lvl_s1_r;
      drv_s1_r <= i_driven;
      drv_s2_r <= drv_s1_r;
    end
  end

  // an undriven pin keeps the last level that was driven onto it
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      hold_r <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (drv_s2_r[i]) begin
          hold_r[i] <= lvl_s2_r[i];
        end
      end
    end
  end

  assign o_level = hold_r;

  a_keeper_holds: assert property (@(posedge i_mclk) disable iff (i_rst)
    (drv_s2_r == '0) |=> $stable(hold_r))
    else $error("keeper changed while pins undriven");
endmodule // pin_keeper

/* rtl/pld_pkg.sv */
// package: constants, register map and carrier types of the low-power logic device block
package pld_pkg;
  localparam int N_INPUTS    = 12;                        // dedicated inputs
  localparam int N_MACROCELL = 10;                        // bidirectional macrocells
  localparam int N_ARRAY     = N_INPUTS + N_MACROCELL;    // array input width
  localparam int SLEEP_IDX   = 3;                         // input shared with the sleep pin
  localparam int SIG_BITS    = 64;                        // identification store
  localparam int SLEEP_EN_BIT = 5893 - 5892 - 1;          // one dedicated enable bit

  // power-up clear interval, longest figure, in ns and cycles of the 40 ns clock
  localparam int CLK_PERIOD_NS     = 40;
  localparam int POWERUP_CLEAR_NS  = 1000;
  localparam int POWERUP_CLEAR_CYC = (POWERUP_CLEAR_NS / CLK_PERIOD_NS < 1) ? 1 :
                                     POWERUP_CLEAR_NS / CLK_PERIOD_NS;

  // register byte addresses
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_STATUS  = 8'h04;
  localparam logic [7:0] ADDR_PRELOAD = 8'h08;
  localparam logic [7:0] ADDR_MCSTATE = 8'h0C;
  localparam logic [7:0] ADDR_SIG_LO  = 8'h10;
  localparam logic [7:0] ADDR_SIG_HI  = 8'h14;
  localparam logic [7:0] ADDR_PINS    = 8'h18;
  localparam logic [7:0] ADDR_MC_BASE = 8'h40;
  localparam logic [7:0] ADDR_MC_LAST = 8'h64;

  // field positions
  localparam int CTRL_SECURE_BIT  = 1;
  localparam int STAT_CLEAR_BIT   = 0;
  localparam int STAT_ASLEEP_BIT  = 1;
  localparam int STAT_SECURE_BIT  = 2;
  localparam int PRE_VALUE_BIT    = 8;
  localparam int PRE_IDX_LSB      = 0;
  localparam int PRE_IDX_W        = 4;

  // reset values
  localparam logic [31:0] SIG_RESET_LO = 32'h0000_0000;   // arbitrary value
  localparam logic [31:0] SIG_RESET_HI = 32'h0000_0000;   // arbitrary value

  // one macrocell configuration word, high bits first
  typedef struct packed {
    logic [6:0]         unused;
    logic               oe;
    logic               active_low;
    logic               registered;
    logic [N_ARRAY-1:0] mask;
  } mc_cfg_t;

  // avalon-mm request as the master drives it
  typedef struct packed {
    logic        read;
    logic        write;
    logic [7:0]  address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } avs_req_t;
endpackage

/* rtl/pld_reset_powerdown_ctrl.sv */
// file: top of the logic device control block: power-up clear, preload, signature,
// security, pin keepers and pin-controlled sleep, registers behind avalon-mm
//
// Overview of operation
// - power-up clears every macrocell register to zero
// - outputs show cleared value through polarity
// - preload forces any register to one/zero
// - 64-bit signature always readable and writable
// - secure bit blocks config readback and preload
// - undriven pins hold last driven level
// - sleep freezes state and latches all outputs
// - undetermined outputs stay so while asleep
// - asleep: all inputs but sleep pin blocked
// - sleep disabled: shared pin is plain input
// - sleep enabled: shared input unused, feedback kept
// - one dedicated bit enables sleep function
// - twelve inputs, ten bidirectional macrocells
// - each macrocell registered/combinational, either polarity
//
// Decided for this implementation: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/100ps
module pld_reset_powerdown_ctrl #(
  parameter int NIN = pld_pkg::N_INPUTS,
  parameter int NMC = pld_pkg::N_MACROCELL
) (
  input  wire logic              i_mclk,
  input  wire logic              i_rst,
  input  wire pld_pkg::avs_req_t i_avs_req,
  output logic [31:0]            o_avs_readdata,
  output logic                   o_avs_waitrequest,
  input  wire logic [NIN-1:0]    i_in_pins,
  input  wire logic [NIN-1:0]    i_in_driven,
  input  wire logic [NMC-1:0]    i_io_in,
  input  wire logic [NMC-1:0]    i_io_driven,
  output logic [NMC-1:0]         o_io_out,
  output logic [NMC-1:0]         o_io_oe
);
  import pld_pkg::*;

  localparam int CNT_W = $clog2(POWERUP_CLEAR_CYC + 1);

  mc_cfg_t           cfg_r [NMC];
  logic [NMC-1:0]    mc_q_r;
  logic [NMC-1:0]    out_r;
  logic [NMC-1:0]    oe_r;
  logic [NIN-1:0]    in_held_r;
  logic [NMC-1:0]    io_held_r;
  logic [NIN-1:0]    in_lvl;
  logic [NMC-1:0]    io_lvl;
  logic              sleep_en_r;
  logic              secure_r;
  logic              clearing_r;
  logic              asleep_r;
  logic [CNT_W-1:0]  por_cnt_r;
  logic [SIG_BITS-1:0] sig_r;
  logic              wait_r;
  logic [31:0]       rdata_r;
  logic [31:0]       rdata_nxt;
  logic              asleep_nxt;
  logic [NIN-1:0]    in_vec;
  logic [NMC-1:0]    fb_vec;
  logic [N_ARRAY-1:0] array_in;
  logic [NMC-1:0]    term;
  logic [NMC-1:0]    pol_vec;
  logic [NMC-1:0]    out_nxt;
  logic              wr_go;
  logic              preload_go;
  logic [PRE_IDX_W-1:0] pl_idx;
  logic              pl_val;

  // keepers for both pin groups; they stay live while asleep
  pin_keeper #(.WIDTH(NIN)) u_in_keep (
    .i_mclk   (i_mclk),
    .i_rst    (i_rst),
    .i_level  (i_in_pins),
    .i_driven (i_in_driven),
    .o_level  (in_lvl)
  );
  pin_keeper #(.WIDTH(NMC)) u_io_keep (
    .i_mclk   (i_mclk),
    .i_rst    (i_rst),
    .i_level  (i_io_in),
    .i_driven (i_io_driven),
    .o_level  (io_lvl)
  );

  // byte-lane merge for register writes
  function automatic logic [31:0] apply_be(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return r;
  endfunction

  // macrocell index from a configuration address, valid only inside the range
  function automatic logic [PRE_IDX_W-1:0] mc_index(input logic [7:0] addr);
    logic [7:0] off;
    off = addr - ADDR_MC_BASE;
    return off[PRE_IDX_W+1:2];
  endfunction

  function automatic logic in_mc_range(input logic [7:0] addr);
    return (addr >= ADDR_MC_BASE) && (addr <= ADDR_MC_LAST) && (addr[1:0] == 2'h0);
  endfunction

  // one wait state: waitrequest drops for the cycle after the request shows
  assign wr_go = i_avs_req.write && !wait_r;
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      wait_r <= 1'b1;
    end else if (wait_r && (i_avs_req.read || i_avs_req.write)) begin
      wait_r <= 1'b0;
    end else begin
      wait_r <= 1'b1;
    end
  end

  // read mux; configuration words read as zero once secured
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    unique case (i_avs_req.address)
      ADDR_CTRL: begin
        rdata_nxt[SLEEP_EN_BIT]    = sleep_en_r;
        rdata_nxt[CTRL_SECURE_BIT] = secure_r;
      end
      ADDR_STATUS: begin
        rdata_nxt[STAT_CLEAR_BIT]  = clearing_r;
        rdata_nxt[STAT_ASLEEP_BIT] = asleep_r;
        rdata_nxt[STAT_SECURE_BIT] = secure_r;
      end
      ADDR_MCSTATE: rdata_nxt[NMC-1:0] = mc_q_r;
      ADDR_SIG_LO:  rdata_nxt = sig_r[31:0];
      ADDR_SIG_HI:  rdata_nxt = sig_r[63:32];
      ADDR_PINS: begin
        rdata_nxt[NIN-1:0]       = in_lvl;
        rdata_nxt[16 +: NMC]     = io_lvl;
      end
      default: begin
        if (in_mc_range(i_avs_req.address) && !secure_r) begin
          rdata_nxt = cfg_r[mc_index(i_avs_req.address)];
        end
      end
    endcase
  end

  // read data is captured while waitrequest is still high, so it stands at the answer
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      rdata_r <= 32'h0000_0000;
    end else if (i_avs_req.read && wait_r) begin
      rdata_r <= rdata_nxt;
    end
  end

  // control bits; the secure bit behaves as a fuse and only reset clears it
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      sleep_en_r <= 1'b0;
      secure_r   <= 1'b0;
    end else if (wr_go && i_avs_req.address == ADDR_CTRL && i_avs_req.byteenable[0]) begin
      sleep_en_r <= i_avs_req.writedata[SLEEP_EN_BIT];
      if (i_avs_req.writedata[CTRL_SECURE_BIT]) begin
        secure_r <= 1'b1;
      end
    end
  end

  // signature store is writable regardless of the secure bit
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      sig_r <= {SIG_RESET_HI, SIG_RESET_LO};
    end else if (wr_go && i_avs_req.address == ADDR_SIG_LO) begin
      sig_r[31:0] <= apply_be(sig_r[31:0], i_avs_req.writedata, i_avs_req.byteenable);
    end else if (wr_go && i_avs_req.address == ADDR_SIG_HI) begin
      sig_r[63:32] <= apply_be(sig_r[63:32], i_avs_req.writedata, i_avs_req.byteenable);
    end
  end

  // macrocell configuration words
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < NMC; i++) begin
        cfg_r[i] <= '0;
      end
    end else if (wr_go && in_mc_range(i_avs_req.address)) begin
      cfg_r[mc_index(i_avs_req.address)] <= apply_be(cfg_r[mc_index(i_avs_req.address)],
                                                     i_avs_req.writedata,
                                                     i_avs_req.byteenable);
    end
  end

  // preload is refused while secured, clearing or asleep; no error shows on the bus
  assign pl_idx     = i_avs_req.writedata[PRE_IDX_LSB +: PRE_IDX_W];
  assign pl_val     = i_avs_req.writedata[PRE_VALUE_BIT];
  assign preload_go = wr_go && (i_avs_req.address == ADDR_PRELOAD) && !secure_r &&
                      !clearing_r && !asleep_r && (pl_idx < PRE_IDX_W'(NMC));

  // power-up clear interval counts from reset release
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      clearing_r <= 1'b1;
      por_cnt_r  <= '0;
    end else if (clearing_r) begin
      if (por_cnt_r == CNT_W'(POWERUP_CLEAR_CYC - 1)) begin
        clearing_r <= 1'b0;
      end
      por_cnt_r <= por_cnt_r + 1'b1;
    end
  end

  // sleep is only honoured with the enable bit set; clearing takes priority
  assign asleep_nxt = sleep_en_r && in_lvl[SLEEP_IDX] && !clearing_r;
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      asleep_r <= 1'b0;
    end else begin
      asleep_r <= asleep_nxt;
    end
  end

  // input latches stop following pins while asleep
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      in_held_r <= '0;
      io_held_r <= '0;
    end else if (!asleep_r) begin
      in_held_r <= in_lvl;
      io_held_r <= io_lvl;
    end
  end

  // shared pin feeds the array only when sleep is not enabled
  always_comb begin
    in_vec = in_held_r;
    if (sleep_en_r) begin
      in_vec[SLEEP_IDX] = 1'b0;
    end
  end

  // product term per macrocell; an empty mask gives zero
  always_comb begin
    for (int i = 0; i < NMC; i++) begin
      fb_vec[i]  = cfg_r[i].registered ? mc_q_r[i] : io_held_r[i];
      pol_vec[i] = cfg_r[i].active_low;
    end
    array_in = {fb_vec, in_vec};
    for (int i = 0; i < NMC; i++) begin
      term[i]    = (cfg_r[i].mask != '0) && ((array_in & cfg_r[i].mask) == cfg_r[i].mask);
      out_nxt[i] = (cfg_r[i].registered ? mc_q_r[i] : term[i]) ^ pol_vec[i];
    end
  end

  // macrocell registers: clear, freeze, preload, then normal clocking
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      mc_q_r <= '0;
    end else if (clearing_r) begin
      mc_q_r <= '0;
    end else if (asleep_r) begin
      mc_q_r <= mc_q_r;
    end else if (preload_go) begin
      mc_q_r[pl_idx] <= pl_val;
    end else begin
      mc_q_r <= term;
    end
  end

  // pin drivers; held exactly as they were while asleep, whatever they were
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      out_r <= '0;
      oe_r  <= '0;
    end else if (clearing_r) begin
      out_r <= pol_vec;
      for (int i = 0; i < NMC; i++) begin
        oe_r[i] <= cfg_r[i].oe;
      end
    end else if (!asleep_r) begin
      out_r <= out_nxt;
      for (int i = 0; i < NMC; i++) begin
        oe_r[i] <= cfg_r[i].oe;
      end
    end
  end

  assign o_io_out          = out_r;
  assign o_io_oe           = oe_r;
  assign o_avs_readdata    = rdata_r;
  assign o_avs_waitrequest = wait_r;

  a_clear_holds_zero: assert property (@(posedge i_mclk) disable iff (i_rst)
    $past(clearing_r) |-> mc_q_r == '0)
    else $error("macrocell register not zero during clear");
  a_clear_length: assert property (@(posedge i_mclk) disable iff (i_rst)
    clearing_r |-> por_cnt_r < CNT_W'(POWERUP_CLEAR_CYC))
    else $error("clear interval overran");
  a_clear_polarity: assert property (@(posedge i_mclk) disable iff (i_rst)
    clearing_r |=> o_io_out == $past(pol_vec))
    else $error("output during clear not polarity of zero");
  a_preload_forces: assert property (@(posedge i_mclk) disable iff (i_rst)
    preload_go |=> mc_q_r[$past(pl_idx)] == $past(pl_val))
    else $error("preload value not loaded");
  a_secure_no_preload: assert property (@(posedge i_mclk) disable iff (i_rst)
    secure_r |-> !preload_go)
    else $error("preload accepted while secured");
  a_secure_cfg_read: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_avs_req.read && wait_r && secure_r && in_mc_range(i_avs_req.address))
      |=> o_avs_readdata == 32'h0000_0000 && !o_avs_waitrequest)
    else $error("configuration readable while secured");
  a_sig_readable: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_avs_req.read && wait_r && i_avs_req.address == ADDR_SIG_HI)
      |=> o_avs_readdata == $past(sig_r[63:32]))
    else $error("signature read mismatch");
  a_sleep_freeze: assert property (@(posedge i_mclk) disable iff (i_rst)
    asleep_r |=> $stable(mc_q_r) && $stable(o_io_out) && $stable(o_io_oe))
    else $error("state changed while asleep");
  a_sleep_hold_long: assert property (@(posedge i_mclk) disable iff (i_rst)
    asleep_r [*3] |-> o_io_out == $past(o_io_out, 2))
    else $error("output drifted during sleep");
  a_sleep_blocks_in: assert property (@(posedge i_mclk) disable iff (i_rst)
    asleep_r |=> $stable(in_held_r) && $stable(io_held_r))
    else $error("inputs not blocked while asleep");
  a_shared_plain_in: assert property (@(posedge i_mclk) disable iff (i_rst)
    !sleep_en_r |-> array_in[SLEEP_IDX] == in_held_r[SLEEP_IDX])
    else $error("shared pin not routed as input");
  a_shared_masked: assert property (@(posedge i_mclk) disable iff (i_rst)
    sleep_en_r |-> array_in[SLEEP_IDX] == 1'b0)
    else $error("shared pin reaches array with sleep enabled");
  a_sleep_enable: assert property (@(posedge i_mclk) disable iff (i_rst)
    !sleep_en_r |=> !asleep_r)
    else $error("sleep entered without enable");
endmodule // pld_reset_powerdown_ctrl

/* verification/board_model.sv */
// board-side model: drives dedicated inputs and macrocell pins around the device
`timescale 1ns/100ps
module board_model (
  input  wire logic                            i_mclk,
  input  wire logic [pld_pkg::N_INPUTS-1:0]    i_in_val,
  input  wire logic [pld_pkg::N_INPUTS-1:0]    i_in_drv,
  input  wire logic [pld_pkg::N_MACROCELL-1:0] i_io_val,
  input  wire logic [pld_pkg::N_MACROCELL-1:0] i_io_drv,
  input  wire logic [pld_pkg::N_MACROCELL-1:0] i_dev_out,
  input  wire logic [pld_pkg::N_MACROCELL-1:0] i_dev_oe,
  output logic      [pld_pkg::N_INPUTS-1:0]    o_in_pins,
  output logic      [pld_pkg::N_INPUTS-1:0]    o_in_driven,
  output logic      [pld_pkg::N_MACROCELL-1:0] o_io_in,
  output logic      [pld_pkg::N_MACROCELL-1:0] o_io_driven
);
  import pld_pkg::*;
  logic [N_INPUTS-1:0]    in_last_r;
  logic [N_MACROCELL-1:0] io_last_r;
  logic [N_MACROCELL-1:0] io_src;
  // remember the last level put on each pin while anyone drives it
  always_ff @(posedge i_mclk) begin
    in_last_r <= (i_in_drv & i_in_val) | (~i_in_drv & in_last_r);
    io_last_r <= (io_src & o_io_in) | (~io_src & io_last_r);
  end
  // levels change only just after a rising edge, so setup is always met
  // a released pin shows the inverse of its last level: only a keeper can hold it
  assign io_src      = i_io_drv | i_dev_oe;
  assign o_io_in     = (i_dev_oe & i_dev_out) | (~i_dev_oe & i_io_drv & i_io_val)
                     | (~io_src & ~io_last_r);
  assign o_io_driven = io_src;
  assign o_in_pins   = (i_in_drv & i_in_val) | (~i_in_drv & ~in_last_r);
  assign o_in_driven = i_in_drv;
endmodule // board_model

/* verification/test_pld_reset_powerdown_ctrl.sv */
// testbench: power-up clear, polarity, sleep, keepers, preload and security
`timescale 1ns/100ps
module test_pld_reset_powerdown_ctrl;
  import pld_pkg::*;
  logic        i_mclk;
  logic        i_rst;
  avs_req_t    req;
  logic [31:0] rdata;
  logic        wait_req;
  logic [11:0] in_val, in_drv, in_pins, in_driven;
  logic [9:0]  io_val, io_drv, io_in, io_driven, io_out, io_oe;
  int          error_cnt;
  int          num_checks;

  pld_reset_powerdown_ctrl uut (.i_mclk(i_mclk), .i_rst(i_rst), .i_avs_req(req),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wait_req), .i_in_pins(in_pins),
    .i_in_driven(in_driven), .i_io_in(io_in), .i_io_driven(io_driven),
    .o_io_out(io_out), .o_io_oe(io_oe));
  board_model board (.i_mclk(i_mclk), .i_in_val(in_val), .i_in_drv(in_drv),
    .i_io_val(io_val), .i_io_drv(io_drv), .i_dev_out(io_out), .i_dev_oe(io_oe),
    .o_in_pins(in_pins), .o_in_driven(in_driven), .o_io_in(io_in),
    .o_io_driven(io_driven));

  // 25 MHz clock
  initial i_mclk = 1'b0;
  always #20 i_mclk = ~i_mclk;

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one avalon transfer: hold everything until waitrequest is sampled low
  task automatic bus(input logic rd, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge i_mclk);
    req <= '{read: rd, write: !rd, address: a, writedata: d, byteenable: 4'hF};
    // no count of its own: a slave that never answers is caught by the watchdog
    do begin
      @(posedge i_mclk);
    end while (wait_req !== 1'b0);
    q = rdata;
    req <= '0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b0, a, d, q);
  endtask

  // read and compare under a mask
  task automatic rc(input string w, input logic [7:0] a, input logic [31:0] m,
                    input logic [31:0] e);
    logic [31:0] q;
    bus(1'b1, a, 32'h0, q);
    chk(w, e, q & m);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge i_mclk);
  endtask

  task automatic t_reset;
    int          n;
    logic [31:0] q;
    n = 0;
    rc("clearing", ADDR_STATUS, 32'h1, 32'h1);
    chk("io_out", 32'h0, {22'h0, io_out});
    // poll until the clear interval is over, bounded
    do begin
      bus(1'b1, ADDR_STATUS, 32'h0, q);
      n++;
    end while (q[0] !== 1'b0 && n < 40);
    chk("clear end", 32'h0, {31'h0, q[0]});
    rc("mc state", ADDR_MCSTATE, 32'h3FF, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_polarity;
    wr(8'h48, 32'h0180_0000);
    wr(8'h4C, 32'h01C0_0000);
    wr(8'h50, 32'h0140_0000);
    cyc(4);
    chk("out 4..2", 32'h3, {29'h0, io_out[4:2]});
    chk("oe 4..2", 32'h7, {29'h0, io_oe[4:2]});
    rc("cfg mc3", 8'h4C, 32'hFFFF_FFFF, 32'h01C0_0000);
    $display("test polarity done");
  endtask

  task automatic t_sleep;
    wr(8'h40, 32'h0140_0001);
    wr(8'h44, 32'h0100_0008);
    in_val <= 12'h009;
    cyc(10);
    chk("shared pin", 32'h3, {30'h0, io_out[1:0]});
    in_val <= 12'h001;
    cyc(8);
    wr(ADDR_CTRL, 32'h1);
    in_val <= 12'h009;
    cyc(8);
    rc("asleep", ADDR_STATUS, 32'h2, 32'h2);
    in_val <= 12'h008;
    cyc(10);
    chk("frozen out", 32'h1, {31'h0, io_out[0]});
    in_val <= 12'h000;
    cyc(10);
    chk("resumed out", 32'h0, {31'h0, io_out[0]});
    rc("awake", ADDR_STATUS, 32'h2, 32'h0);
    wr(ADDR_CTRL, 32'h0);
    $display("test sleep done");
  endtask

  task automatic t_keeper;
    in_val <= 12'hA52;
    io_val <= 10'h2A0;
    io_drv <= 10'h3E0;
    cyc(8);
    rc("driven pins", ADDR_PINS, 32'h03E0_0FFF, 32'h02A0_0A52);
    in_drv <= 12'h000;
    io_drv <= 10'h000;
    cyc(8);
    rc("kept pins", ADDR_PINS, 32'h03E0_0FFF, 32'h02A0_0A52);
    $display("test keeper done");
  endtask

  task automatic t_preload;
    // cells 5, 6 and 9 feed back on themselves, so a forced value outlives the next clock
    wr(8'h54, 32'h0042_0000);
    wr(8'h58, 32'h0044_0000);
    wr(8'h64, 32'h0060_0000);
    wr(ADDR_PRELOAD, 32'h105);
    wr(ADDR_PRELOAD, 32'h109);
    rc("preload one", ADDR_MCSTATE, 32'h220, 32'h220);
    wr(ADDR_PRELOAD, 32'h005);
    wr(ADDR_PRELOAD, 32'h10A);
    rc("preload zero", ADDR_MCSTATE, 32'h220, 32'h200);
    $display("test preload done");
  endtask

  task automatic t_secure;
    wr(ADDR_SIG_LO, 32'hCAFE_0123);
    wr(ADDR_SIG_HI, 32'h4567_89AB);
    wr(ADDR_CTRL, 32'h2);
    rc("secure", ADDR_STATUS, 32'h4, 32'h4);
    rc("cfg hidden", 8'h4C, 32'hFFFF_FFFF, 32'h0);
    wr(ADDR_PRELOAD, 32'h106);
    rc("preload blocked", ADDR_MCSTATE, 32'h40, 32'h0);
    rc("sig lo", ADDR_SIG_LO, 32'hFFFF_FFFF, 32'hCAFE_0123);
    rc("sig hi", ADDR_SIG_HI, 32'hFFFF_FFFF, 32'h4567_89AB);
    rc("unmapped", 8'h80, 32'hFFFF_FFFF, 32'h0);
    $display("test secure done");
  endtask

  task automatic finish_test;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge i_mclk);
    error_cnt++;
    $display("[ERR] watchdog expected done seen timeout");
    finish_test();
  end

  // main sequence; security goes last because it cannot be undone
  initial begin
    error_cnt = 0;
    num_checks = 0;
    i_rst = 1'b1;
    req = '0;
    in_val = 12'h000;
    in_drv = 12'hFFF;
    io_val = 10'h000;
    io_drv = 10'h3FF;
    repeat (4) @(posedge i_mclk);
    i_rst <= 1'b0;
    t_reset();
    t_polarity();
    t_sleep();
    t_keeper();
    in_drv <= 12'hFFF;
    t_preload();
    t_secure();
    finish_test();
  end
endmodule // test_pld_reset_powerdown_ctrl
